/* File: include/adc_config_regs.svh */
`ifndef ADC_CONFIG_REGS_SVH
`define ADC_CONFIG_REGS_SVH

// Pointer value that selects the operating setup store.
`define SETUP_POINTER 4'h2
// Operating setup store value loaded at power-up.
`define SETUP_RESET 8'h08

`define SETUP_UNUSED_TOP_BIT 7
`define SETUP_EXT_REF_BIT 6
`define SETUP_SECOND_INPUT_SELECT_BIT 5
`define SETUP_FIRST_INPUT_SELECT_BIT 4
`define SETUP_BUS_GLITCH_FILTER_ENABLE_BIT 3
`define SETUP_PIN_FN_HI_BIT 2
`define SETUP_PIN_FN_LO_BIT 1
`define SETUP_PIN_POLARITY_BIT 0

`define PIN_FN_NONE 2'h0
`define PIN_FN_BUSY 2'h1
`define PIN_FN_LIMIT 2'h2
`define PIN_FN_CLEAR 2'h3
`define PIN_FN_AFTER_CLEAR 2'h2

`define SEL_NONE 3'h0
`define SEL_FIRST_SUPPLY 3'h1
`define SEL_FIRST_EXTERNAL 3'h5
`define SEL_SECOND_SUPPLY 3'h2
`define SEL_ALTERNATE_SUPPLY 3'h3

// Glitch suppression span on the bus lines, and the clock period.
`define FILTER_SPAN_NS 50
`define CLK_PERIOD_NS 100
`define FILTER_CYCLES_RAW ((`FILTER_SPAN_NS) / (`CLK_PERIOD_NS))
`define FILTER_CYCLES ((`FILTER_CYCLES_RAW < 1) ? 1 : `FILTER_CYCLES_RAW)

`endif

/* File: include/adc_config_pkg.sv */
package adc_config_pkg;

  typedef struct packed {
    logic strobe;
    logic first;
    logic [7:0] data;
  } bus_byte_type;

  typedef struct packed {
    logic active;
    logic second;
    logic ext_ref;
  } conv_ctl_type;

  typedef enum logic [2:0] {
    SEQ_OFF = 3'b001,
    SEQ_FIRST = 3'b010,
    SEQ_SECOND = 3'b100
  } seq_state_type;

  typedef struct packed {
    logic [3:0] pointer;
    logic data_taken;
    logic setup_wr;
    logic [7:0] setup_data;
  } router_state_type;

  typedef struct packed {
    seq_state_type state;
    conv_ctl_type ctl;
  } seq_reg_type;

  typedef struct packed {
    logic [7:0] setup;
    logic clear;
    logic pin_o;
    logic pin_oe;
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] filt;
    logic [1:0][1:0] cnt;
  } setup_state_type;

endpackage : adc_config_pkg

/* File: core/serial_byte_router.sv */
`include "adc_config_regs.svh"

module serial_byte_router
  import adc_config_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire bus_byte_type bus_byte,
  output logic [3:0] pointer,
  output logic setup_wr,
  output logic [7:0] setup_data
);

  router_state_type state_q;
  router_state_type state_d;

  always_comb
  begin
    state_d = state_q;
    state_d.setup_wr = 1'b0;
    if (bus_byte.strobe)
    begin
      if (bus_byte.first)
      begin
        state_d.pointer = bus_byte.data[3:0];
        state_d.data_taken = 1'b0;
      end
      else if (!state_q.data_taken)
      begin
        // Only one data byte per write reaches the store; later ones drop.
        state_d.data_taken = 1'b1;
        if (state_q.pointer == `SETUP_POINTER)
        begin
          state_d.setup_wr = 1'b1;
          state_d.setup_data = bus_byte.data;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign pointer = state_q.pointer;
  assign setup_wr = state_q.setup_wr;
  assign setup_data = state_q.setup_data;

endmodule : serial_byte_router

/* File: core/conversion_sequencer.sv */
`include "adc_config_regs.svh"

module conversion_sequencer
  import adc_config_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic restart,
  input wire logic [2:0] select,
  input wire logic conv_done,
  output conv_ctl_type ctl
);

  seq_reg_type state_q;
  seq_reg_type state_d;

  always_comb
  begin
    state_d = state_q;
    if (restart)
    begin
      case (select)
        `SEL_FIRST_SUPPLY:
        begin
          state_d.state = SEQ_FIRST;
          state_d.ctl = '{active: 1'b1, second: 1'b0, ext_ref: 1'b0};
        end
        `SEL_FIRST_EXTERNAL:
        begin
          state_d.state = SEQ_FIRST;
          state_d.ctl = '{active: 1'b1, second: 1'b0, ext_ref: 1'b1};
        end
        `SEL_SECOND_SUPPLY:
        begin
          state_d.state = SEQ_SECOND;
          state_d.ctl = '{active: 1'b1, second: 1'b1, ext_ref: 1'b0};
        end
        `SEL_ALTERNATE_SUPPLY:
        begin
          state_d.state = SEQ_FIRST;
          state_d.ctl = '{active: 1'b1, second: 1'b0, ext_ref: 1'b0};
        end
        default:
        begin
          // Unlisted codes, including external reference with the second
          // input, leave the converter idle.
          state_d.state = SEQ_OFF;
          state_d.ctl = '0;
        end
      endcase
    end
    else if (conv_done && select == `SEL_ALTERNATE_SUPPLY)
    begin
      case (state_q.state)
        SEQ_FIRST:
        begin
          state_d.state = SEQ_SECOND;
          state_d.ctl.second = 1'b1;
        end
        SEQ_SECOND:
        begin
          state_d.state = SEQ_FIRST;
          state_d.ctl.second = 1'b0;
        end
        default:
        begin
          state_d.state = state_q.state;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q.state <= SEQ_OFF;
      state_q.ctl <= '0;
    end
    else
      state_q <= state_d;
  end

  assign ctl = state_q.ctl;

endmodule : conversion_sequencer

/* File: core/adc_config_register.sv */
`include "adc_config_regs.svh"

module adc_config_register
  import adc_config_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire bus_byte_type BUS_BYTE,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic CONV_BUSY,
  input wire logic LIMIT_ALERT,
  input wire logic CONV_DONE,
  output logic [3:0] POINTER,
  output logic [7:0] SETUP_READBACK,
  output conv_ctl_type CONV_CTL,
  output logic FILTER_ENABLE,
  output logic SCL_FILT,
  output logic SDA_FILT,
  output logic ALERT_CLEAR,
  output logic ALERT_BUSY_O,
  output logic ALERT_BUSY_OE
);

  localparam logic [1:0] FILTER_LAST = 2'(`FILTER_CYCLES - 1);

  setup_state_type state_q;
  setup_state_type state_d;
  logic setup_wr;
  logic [7:0] setup_data;
  logic [1:0] pin_fn;
  logic pin_active;

  serial_byte_router router_inst (
    .clk(SYS_CLK),
    .nrst(NRST),
    .bus_byte(BUS_BYTE),
    .pointer(POINTER),
    .setup_wr(setup_wr),
    .setup_data(setup_data)
  );

  // The sequencer sees the stored selection one cycle after the write, so
  // it restarts on setup_wr delayed one cycle by its own flop, restart_q.
  logic restart_q;

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
      restart_q <= 1'b0;
    else
      restart_q <= setup_wr;
  end

  conversion_sequencer seq_inst (
    .clk(SYS_CLK),
    .nrst(NRST),
    .restart(restart_q),
    .select(state_q.setup[`SETUP_EXT_REF_BIT:`SETUP_FIRST_INPUT_SELECT_BIT]),
    .conv_done(CONV_DONE),
    .ctl(CONV_CTL)
  );

  always_comb
  begin
    state_d = state_q;
    state_d.clear = 1'b0;
    // Store update; bit 7 is kept only so that it reads back.
    if (setup_wr)
    begin
      state_d.setup = setup_data;
      if (setup_data[`SETUP_PIN_FN_HI_BIT:`SETUP_PIN_FN_LO_BIT] ==
          `PIN_FN_CLEAR)
      begin
        state_d.clear = 1'b1;
        state_d.setup[`SETUP_PIN_FN_HI_BIT:`SETUP_PIN_FN_LO_BIT] =
          `PIN_FN_AFTER_CLEAR;
      end
    end
    // Bus lines come from pins: two flops before anything reads them.
    state_d.meta = {SDA_IN, SCL_IN};
    state_d.sync = state_q.meta;
    for (int i = 0; i < 2; i++)
    begin
      if (!state_q.setup[`SETUP_BUS_GLITCH_FILTER_ENABLE_BIT])
      begin
        state_d.filt[i] = state_q.sync[i];
        state_d.cnt[i] = 2'h0;
      end
      else if (state_q.sync[i] != state_q.filt[i])
      begin
        // A level must persist the full span before it is passed on.
        if (state_q.cnt[i] >= FILTER_LAST)
        begin
          state_d.filt[i] = state_q.sync[i];
          state_d.cnt[i] = 2'h0;
        end
        else
          state_d.cnt[i] = state_q.cnt[i] + 2'h1;
      end
      else
        state_d.cnt[i] = 2'h0;
    end
    // Output pin: function from bits 2:1, polarity from bit 0.
    pin_fn = state_q.setup[`SETUP_PIN_FN_HI_BIT:`SETUP_PIN_FN_LO_BIT];
    case (pin_fn)
      `PIN_FN_BUSY:
        pin_active = CONV_BUSY;
      `PIN_FN_LIMIT:
        pin_active = LIMIT_ALERT && !state_q.clear;
      default:
        pin_active = 1'b0;
    endcase
    state_d.pin_oe = (pin_fn == `PIN_FN_BUSY) || (pin_fn == `PIN_FN_LIMIT);
    if (state_q.setup[`SETUP_PIN_POLARITY_BIT])
      state_d.pin_o = pin_active;
    else
      state_d.pin_o = !pin_active;
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_q <= '0;
      state_q.setup <= `SETUP_RESET;
      state_q.pin_o <= 1'b1;
      state_q.meta <= 2'h3;
      state_q.sync <= 2'h3;
      state_q.filt <= 2'h3;
    end
    else
      state_q <= state_d;
  end

  assign SETUP_READBACK = state_q.setup;
  assign FILTER_ENABLE = state_q.setup[`SETUP_BUS_GLITCH_FILTER_ENABLE_BIT];
  assign SCL_FILT = state_q.filt[0];
  assign SDA_FILT = state_q.filt[1];
  assign ALERT_CLEAR = state_q.clear;
  assign ALERT_BUSY_O = state_q.pin_o;
  assign ALERT_BUSY_OE = state_q.pin_oe;

endmodule : adc_config_register

/* File: tb/adc_config_register_asserts.sv */
module adc_config_register_asserts
  import adc_config_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire bus_byte_type BUS_BYTE,
  input wire logic CONV_BUSY,
  input wire logic LIMIT_ALERT,
  input wire logic CONV_DONE,
  input wire logic [3:0] POINTER,
  input wire logic [7:0] SETUP_READBACK,
  input wire conv_ctl_type CONV_CTL,
  input wire logic ALERT_CLEAR,
  input wire logic ALERT_BUSY_O,
  input wire logic ALERT_BUSY_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  logic fresh_q;
  logic take;
  logic [2:0] sel;
  // Only the first data byte after a pointer byte may reach the store.
  always_ff @(posedge SYS_CLK or negedge NRST)
    if (!NRST)
      fresh_q <= 1'b0;
    else if (BUS_BYTE.strobe)
      fresh_q <= BUS_BYTE.first;
  assign take = BUS_BYTE.strobe && !BUS_BYTE.first && POINTER == 4'h2 &&
    fresh_q;
  assign sel = SETUP_READBACK[6:4];
  function automatic logic [2:0] ctl_for(input logic [2:0] s);
    case (s)
      3'h1: ctl_for = 3'h4;
      3'h5: ctl_for = 3'h5;
      3'h2: ctl_for = 3'h6;
      default: ctl_for = 3'h0;
    endcase
  endfunction : ctl_for
  sequence setup_take;
    take;
  endsequence
  sequence clear_take;
    setup_take ##0 BUS_BYTE.data[2:1] == 2'h3;
  endsequence
  sequence plain_take;
    setup_take ##0 BUS_BYTE.data[2:1] != 2'h3;
  endsequence
  sequence steady;
    $stable(SETUP_READBACK)[*3];
  endsequence
  chk_pointer_load: assert property (
    BUS_BYTE.strobe && BUS_BYTE.first |=> POINTER == $past(BUS_BYTE.data[3:0]))
    else $error("pointer not loaded");
  chk_setup_write: assert property (setup_take |-> ##2
    SETUP_READBACK[7:3] == $past(BUS_BYTE.data[7:3], 2))
    else $error("setup store not written");
  chk_setup_low: assert property (plain_take |-> ##2
    SETUP_READBACK[2:0] == $past(BUS_BYTE.data[2:0], 2))
    else $error("setup low bits not written");
  chk_clear_readback: assert property (clear_take |-> ##2
    SETUP_READBACK[2:0] == {2'h2, $past(BUS_BYTE.data[0], 2)})
    else $error("clear command read back wrong");
  chk_clear_pulse: assert property (
    clear_take |-> ##2 ALERT_CLEAR ##1 !ALERT_CLEAR)
    else $error("clear pulse wrong");
  chk_pin_enable: assert property (
    ALERT_BUSY_OE == ($past(SETUP_READBACK[2:1]) != 2'h0))
    else $error("pin enable wrong");
  chk_busy_level: assert property (
    SETUP_READBACK[2:1] == 2'h1 && $stable(SETUP_READBACK)
    |=> ALERT_BUSY_O == ($past(CONV_BUSY) ~^ $past(SETUP_READBACK[0])))
    else $error("busy pin level wrong");
  chk_limit_level: assert property (
    SETUP_READBACK[2:1] == 2'h2 && $stable(SETUP_READBACK) && !ALERT_CLEAR
    |=> ALERT_BUSY_O == ($past(LIMIT_ALERT) ~^ $past(SETUP_READBACK[0])))
    else $error("limit pin level wrong");
  chk_sel_decode: assert property (
    steady ##0 sel != 3'h3 |-> CONV_CTL == ctl_for(sel))
    else $error("selection decode wrong");
  chk_alt_toggle: assert property (
    steady ##0 sel == 3'h3 && CONV_DONE
    |=> CONV_CTL.second != $past(CONV_CTL.second))
    else $error("alternation did not toggle");
endmodule : adc_config_register_asserts

bind adc_config_register adc_config_register_asserts i_chk (.SYS_CLK, .NRST,
  .BUS_BYTE, .CONV_BUSY, .LIMIT_ALERT, .CONV_DONE, .POINTER, .SETUP_READBACK,
  .CONV_CTL, .ALERT_CLEAR, .ALERT_BUSY_O, .ALERT_BUSY_OE);

/* File: tb/bus_host_model.sv */
module bus_host_model
  import adc_config_pkg::*;
(
  input wire logic clk,
  output bus_byte_type bus_byte,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pulled-up lines rest high while no transfer runs.
  initial
  begin
    bus_byte = '0;
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic write(input logic [3:0] ptr, input logic [7:0] data,
                       input logic extra);
    @(posedge clk);
    bus_byte <= '{1'b1, 1'b1, {4'h0, ptr}};
    @(posedge clk);
    bus_byte <= '{1'b1, 1'b0, data};
    if (extra)
    begin
      @(posedge clk);
      bus_byte <= '{1'b1, 1'b0, ~data};
    end
    @(posedge clk);
    bus_byte <= '0;
  endtask : write
  task automatic lines(input logic c, input logic d);
    @(posedge clk);
    scl <= c;
    sda <= d;
  endtask : lines
endmodule : bus_host_model

/* File: tb/adc_config_register_test.sv */
module adc_config_register_test;
  import adc_config_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, busy, limit, done, f_en, scl_f, sda_f, clr, pin_o, pin_oe;
  logic scl, sda;
  bus_byte_type bb;
  logic [3:0] ptr;
  logic [7:0] rb;
  conv_ctl_type ctl;
  int bad_count = 0;
  int comparisons = 0;
  int clears = 0;
  bus_host_model i_host (.clk(clk), .bus_byte(bb), .scl(scl), .sda(sda));
  adc_config_register i_dut (.SYS_CLK(clk), .NRST(nrst), .BUS_BYTE(bb),
    .SCL_IN(scl), .SDA_IN(sda), .CONV_BUSY(busy), .LIMIT_ALERT(limit),
    .CONV_DONE(done), .POINTER(ptr), .SETUP_READBACK(rb), .CONV_CTL(ctl),
    .FILTER_ENABLE(f_en), .SCL_FILT(scl_f), .SDA_FILT(sda_f),
    .ALERT_CLEAR(clr), .ALERT_BUSY_O(pin_o), .ALERT_BUSY_OE(pin_oe));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
    if (clr === 1'b1)
      clears++;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic final_report;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // The wait covers the slowest answer to a write, the conversion control.
  task automatic setup(input logic [7:0] v, input logic extra);
    i_host.write(4'h2, v, extra);
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : setup
  task automatic t_reset;
    @(negedge clk);
    check(rb, 8'h08);
    check({4'h0, ptr}, 8'h00);
    check({6'h0, f_en, pin_oe}, 8'h02);
  endtask : t_reset
  task automatic t_alternate;
    setup(8'hB5, 1'b0);
    check(rb, 8'hB5);
    check({7'h0, f_en}, 8'h00);
    check({5'h0, ctl}, 8'h04);
    check({6'h0, pin_oe, pin_o}, 8'h03);
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    @(negedge clk);
    check({5'h0, ctl}, 8'h06);
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    @(negedge clk);
    check({5'h0, ctl}, 8'h04);
  endtask : t_alternate
  task automatic t_decode;
    // Bit 6 stays clear whenever the second input is selected.
    logic [7:0] cfg [5] = '{8'h18, 8'h48, 8'h58, 8'h28, 8'h08};
    logic [7:0] exp [5] = '{8'h04, 8'h00, 8'h05, 8'h06, 8'h00};
    for (int i = 0; i < 5; i++)
    begin
      setup(cfg[i], 1'b0);
      check({5'h0, ctl}, exp[i]);
    end
  endtask : t_decode
  task automatic t_clear;
    clears = 0;
    setup(8'h0F, 1'b1);
    check(rb, 8'h0D);
    check(clears[7:0], 8'h01);
    check({6'h0, pin_oe, pin_o}, 8'h03);
    @(posedge clk);
    limit <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({6'h0, pin_oe, pin_o}, 8'h02);
    @(posedge clk);
    limit <= 1'b1;
  endtask : t_clear
  task automatic t_busy_pin;
    @(posedge clk);
    busy <= 1'b1;
    setup(8'h03, 1'b0);
    check({7'h0, pin_o}, 8'h01);
    setup(8'h02, 1'b0);
    check({7'h0, pin_o}, 8'h00);
    i_host.write(4'h3, 8'hFF, 1'b0);
    @(negedge clk);
    check({rb[3:0], ptr}, 8'h23);
  endtask : t_busy_pin
  task automatic t_filter;
    i_host.lines(1'b0, 1'b0);
    repeat (6) @(posedge clk);
    @(negedge clk);
    check({6'h0, scl_f, sda_f}, 8'h00);
    setup(8'h08, 1'b0);
    i_host.lines(1'b1, 1'b0);
    repeat (6) @(posedge clk);
    @(negedge clk);
    check({5'h0, f_en, scl_f, sda_f}, 8'h06);
  endtask : t_filter
  initial
  begin
    nrst = 1'b0;
    busy = 1'b0;
    limit = 1'b1;
    done = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_alternate();
    t_decode();
    t_clear();
    t_busy_pin();
    t_filter();
    final_report();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule : adc_config_register_test
